//--- design/irq_source_defs.svh
`ifndef IRQ_SOURCE_DEFS_SVH
`define IRQ_SOURCE_DEFS_SVH
// indexed register bank (bank select high)
`define IDX_SOURCE_SELECT      8'h02
`define IDX_CONFIG_LO          8'h04
`define IDX_CONFIG_HI          8'h05
`define IDX_THRESH_B0          8'h08
`define IDX_THRESH_B1          8'h09
`define IDX_THRESH_B2          8'h0A
`define IDX_THRESH_B3          8'h0B
// configuration byte 1 field positions
`define CFG_ENH_BIT            7
`define CFG_BANK_BIT           6
`define CFG_BLOCK_BIT          5
`define CFG_SYNC_BIT           4
// shared source codes, plus counter-only SRC_SAMPLE
`define SRC_THRESH             4'h2
`define SRC_FRAME_MAX          4'h3
`define SRC_TRIG_START         4'h4
`define SRC_TRIG_STOP          4'h5
`define SRC_SAMPLE             4'h1
// counter source 0010 counts blocks of this many samples
`define BLOCK_SAMPLES          9'h100
`define RESET_BYTE             8'h00
`define RESET_WORD32           32'h00000000
`endif

//--- design/irq_source_pkg.sv
package irq_source_pkg;
   typedef logic [3:0] src_code_t;
   typedef logic [7:0] index_t;
endpackage

//--- design/input_edge_sync.sv
`timescale 1ns/1ps
`default_nettype none
module input_edge_sync #(
   parameter int WIDTH = 4
) (
   input  wire logic             sys_clk,  // board clock
   input  wire logic             rst,      // sync reset
   input  wire logic [WIDTH-1:0] pin_in,   // asynchronous pins
   output logic      [WIDTH-1:0] rise,     // one-cycle rising pulse
   output logic      [WIDTH-1:0] fall      // one-cycle falling pulse
);
   logic [WIDTH-1:0] s1;
   logic [WIDTH-1:0] s2;
   logic [WIDTH-1:0] s3;
   logic [WIDTH-1:0] stable;
   wire  [WIDTH-1:0] agree = ~(s2 ^ s3);
   wire  [WIDTH-1:0] next_stable = (agree & s3) | (~agree & stable);

   // R17: synchronise and detect
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         s1     <= '0;
         s2     <= '0;
         s3     <= '0;
         stable <= '0;
         rise   <= '0;
         fall   <= '0;
      end
      else
      begin
         s1     <= pin_in;
         s2     <= s1;
         s3     <= s2;
         stable <= next_stable;
         rise   <= next_stable & ~stable;
         fall   <= ~next_stable & stable;
      end
   end
endmodule // input_edge_sync
`default_nettype wire

//--- design/irq_source_config.sv
// Functional notes
// R1: source B codes: none, reserved, threshold, frame max, trig start, trig stop.
// R2: source A uses same codes and sets its own flag independently.
// R3: codes 1000-1111 pick digital input 0-3, even rising, odd falling.
// R4: bank enable 1 shows source flags in status low nibble, else channel.
// R5: source flags set only while bank enable is 1.
// R6: enhanced selection bit picks normal or enhanced control meaning.
// R7: block bit 1 suppresses classic sample and burst interrupts.
// R8: DMA enable overrides the block bit.
// R9: classic DMA and FIFO interrupts ignore the block bit.
// R10: counter source codes: never, sample/frame, 256-sample block, frame max, trig edges.
// R11: counter upper codes pick digital input edges as selectors do.
// R12: sync bit clears threshold counter at each trigger start.
// R13: all source fields and control bits reset to zero.
// R14: config reachable as bytes 0x04, 0x05 or one 16-bit word.
// R15: counter reaching threshold produces a one-cycle output pulse.
// R16: index advances by access size unless auto increment disabled.
// R17: digital inputs synchronised, each edge a single-cycle event.
// R18: none and reserved codes give no event but read back unchanged.
`timescale 1ns/1ps
`default_nettype none
`include "irq_source_defs.svh"
module irq_source_config
   import irq_source_pkg::*;
#(
   parameter int DIN_WIDTH = 4
) (
   input  wire logic                 sys_clk,          // board clock 40 MHz
   input  wire logic                 rst,              // sync reset, high
   input  wire logic                 indexed_bank_select, // bank select bit
   input  wire logic                 auto_index_increment_disable, // freeze index
   input  wire logic                 index_load,       // load index pulse
   input  wire logic [7:0]           index_load_value, // new index
   input  wire logic                 reg_wr,           // write strobe
   input  wire logic                 reg_rd,           // read strobe
   input  wire logic                 reg_word,         // 16-bit access
   input  wire logic [15:0]          reg_wdata,        // write data
   input  wire logic [DIN_WIDTH-1:0] digital_input,    // input pins
   input  wire logic [3:0]           adc_channel,      // current channel
   input  wire logic                 sample_done,      // sample/frame pulse
   input  wire logic                 frame_max,        // frame max pulse
   input  wire logic                 trig_start,       // trigger active pulse
   input  wire logic                 trig_stop,        // trigger inactive pulse
   input  wire logic                 status_flag_clear,// clear source flags
   input  wire logic                 classic_irq_req,  // sample/burst irq
   input  wire logic                 dma_irq_req,      // classic dma irq
   input  wire logic                 fifo_irq_req,     // fifo irq
   input  wire logic                 dma_enable,       // dma bit
   output logic [15:0]               reg_rdata,        // read data
   output logic [7:0]                index,            // current index
   output logic [3:0]                status_low_nibble,// status low nibble
   output logic                      source_a_flag,    // source A flag
   output logic                      source_b_flag,    // source B flag
   output logic                      enhanced_selection, // enhanced meaning
   output logic                      irq_request,      // combined classic irq
   output logic                      threshold_pulse   // threshold reached
);
   logic [3:0]  source_a_select;
   logic [3:0]  source_b_select;
   logic [3:0]  fifo_block_count;
   logic [3:0]  threshold_counter_source;
   logic        status_bank_enable;
   logic        classic_interrupt_block;
   logic        threshold_trigger_sync;
   logic [31:0] threshold_value;
   logic [31:0] thresh_count;
   logic [8:0]  block_count;
   logic [DIN_WIDTH-1:0] din_rise;
   logic [DIN_WIDTH-1:0] din_fall;

   input_edge_sync #(.WIDTH(DIN_WIDTH)) u_sync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .pin_in  (digital_input),
      .rise    (din_rise),
      .fall    (din_fall)
   );

   wire block_tick = sample_done && (block_count == `BLOCK_SAMPLES - 9'h001);

   // edges in code order 1000..1111: rise then fall for each input
   wire [7:0] din_edges = {din_fall[3], din_rise[3], din_fall[2], din_rise[2],
                           din_fall[1], din_rise[1], din_fall[0], din_rise[0]};
   wire [2:0] pulse_events = {trig_stop, trig_start, frame_max};

   // R1: decode shared codes (reserved, none give zero per R18)
   // all events are arguments: a continuous assignment re-evaluates only on its operands
   function automatic logic src_event(input src_code_t code, input logic thr,
                                      input logic [2:0] pulses, input logic [7:0] edges);
      if (code[3])
         // R3: input edges
         src_event = edges[code[2:0]];
      else
         case (code)
            `SRC_THRESH:     src_event = thr;
            `SRC_FRAME_MAX:  src_event = pulses[0];
            `SRC_TRIG_START: src_event = pulses[1];
            `SRC_TRIG_STOP:  src_event = pulses[2];
            default:         src_event = 1'b0;
         endcase
   endfunction

   // R10: counter source decode, R11 input edges via same function
   wire count_event = (threshold_counter_source == `SRC_SAMPLE) ? sample_done :
                      (threshold_counter_source == `SRC_THRESH) ? block_tick :
                      src_event(threshold_counter_source, 1'b0, pulse_events, din_edges);
   wire [31:0] count_inc = thresh_count + 32'h00000001;
   // R15: reach on the counting event
   wire        reach = count_event && (count_inc == threshold_value);
   // R2: independent flag events, R5 gated by bank enable
   wire        a_event = status_bank_enable &&
                         src_event(source_a_select, threshold_pulse, pulse_events, din_edges);
   wire        b_event = status_bank_enable &&
                         src_event(source_b_select, threshold_pulse, pulse_events, din_edges);

   wire wr_lo  = reg_wr && indexed_bank_select;
   wire hit_sel = wr_lo && index == `IDX_SOURCE_SELECT;
   // R14: byte or word access to config
   wire hit_clo = wr_lo && index == `IDX_CONFIG_LO;
   wire hit_chi = wr_lo && (index == `IDX_CONFIG_HI || (index == `IDX_CONFIG_LO && reg_word));
   wire [7:0] hi_data = (index == `IDX_CONFIG_HI) ? reg_wdata[7:0] : reg_wdata[15:8];
   wire [7:0] thr_base = `IDX_THRESH_B0;
   wire thr_wr = wr_lo && index[7:2] == thr_base[7:2];

   // R16: index advance
   wire [7:0] step = reg_word ? 8'h02 : 8'h01;
   wire [7:0] next_index = index_load ? index_load_value :
      ((reg_wr || reg_rd) && !auto_index_increment_disable) ? index + step : index;

   wire [15:0] cfg_word = {enhanced_selection, status_bank_enable, classic_interrupt_block,
                           threshold_trigger_sync, threshold_counter_source,
                           4'h0, fifo_block_count};
   wire [15:0] thr_half = index[1] ? threshold_value[31:16] : threshold_value[15:0];
   wire [15:0] next_rdata =
      !indexed_bank_select               ? 16'h0000 :
      (index == `IDX_SOURCE_SELECT)      ? {8'h00, source_b_select, source_a_select} :
      (index == `IDX_CONFIG_LO)          ? cfg_word :
      (index == `IDX_CONFIG_HI)          ? {8'h00, cfg_word[15:8]} :
      (index[7:2] == thr_base[7:2])      ? (index[0] ? {8'h00, thr_half[15:8]} : thr_half) :
      16'h0000;

   // R7: block classic, R8 dma override, R9 dma/fifo untouched
   wire next_irq = (classic_irq_req && (!classic_interrupt_block || dma_enable))
                   || dma_irq_req || fifo_irq_req;
   // R4: status nibble mux
   wire [3:0] next_nibble = status_bank_enable ?
      {2'b00, (source_b_flag || b_event), (source_a_flag || a_event)} : adc_channel;

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         // R13: reset to zero
         source_a_select          <= 4'h0;
         source_b_select          <= 4'h0;
         fifo_block_count         <= 4'h0;
         threshold_counter_source <= 4'h0;
         enhanced_selection       <= 1'b0;
         status_bank_enable       <= 1'b0;
         classic_interrupt_block  <= 1'b0;
         threshold_trigger_sync   <= 1'b0;
         index                    <= `RESET_BYTE;
      end
      else
      begin
         index <= next_index;
         // R18: all codes stored as written
         if (hit_sel)
         begin
            source_a_select <= reg_wdata[3:0];
            source_b_select <= reg_wdata[7:4];
         end
         if (hit_clo)
            fifo_block_count <= reg_wdata[3:0];
         if (hit_chi)
         begin
            // R6: enhanced selection bit
            enhanced_selection       <= hi_data[`CFG_ENH_BIT];
            status_bank_enable       <= hi_data[`CFG_BANK_BIT];
            classic_interrupt_block  <= hi_data[`CFG_BLOCK_BIT];
            threshold_trigger_sync   <= hi_data[`CFG_SYNC_BIT];
            threshold_counter_source <= hi_data[3:0];
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         threshold_value <= `RESET_WORD32;
         thresh_count    <= `RESET_WORD32;
         block_count     <= 9'h000;
         threshold_pulse <= 1'b0;
      end
      else
      begin
         if (thr_wr)
         begin
            if (index[0])
               threshold_value[{index[1], 4'h8} +: 8] <= reg_wdata[7:0];
            else if (reg_word)
               threshold_value[{index[1], 4'h0} +: 16] <= reg_wdata;
            else
               threshold_value[{index[1], 4'h0} +: 8] <= reg_wdata[7:0];
         end
         // wrap on the tick, else a 9-bit count would tick only every 512 samples
         if (sample_done)
            block_count <= block_tick ? 9'h000 : block_count + 9'h001;
         threshold_pulse <= reach;
         // R12: trigger sync clear wins over counting
         if (threshold_trigger_sync && trig_start)
            thresh_count <= `RESET_WORD32;
         else if (reach)
            thresh_count <= `RESET_WORD32;
         else if (count_event)
            thresh_count <= count_inc;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         source_a_flag     <= 1'b0;
         source_b_flag     <= 1'b0;
         reg_rdata         <= 16'h0000;
         status_low_nibble <= 4'h0;
         irq_request       <= 1'b0;
      end
      else
      begin
         // set wins over clear
         source_a_flag     <= a_event || (source_a_flag && !status_flag_clear);
         source_b_flag     <= b_event || (source_b_flag && !status_flag_clear);
         reg_rdata         <= next_rdata;
         status_low_nibble <= next_nibble;
         irq_request       <= next_irq;
      end
   end
endmodule // irq_source_config
`default_nettype wire

//--- tb/irq_source_checker.sv
`timescale 1ns/1ps
`default_nettype none
module irq_source_checker (
   input wire logic        sys_clk,                      // clock
   input wire logic        rst,                          // reset
   input wire logic        indexed_bank_select,          // bank
   input wire logic        auto_index_increment_disable, // freeze
   input wire logic        index_load,                   // load
   input wire logic [7:0]  index_load_value,             // load value
   input wire logic        reg_wr,                       // write
   input wire logic        reg_word,                     // word
   input wire logic        status_flag_clear,            // clear
   input wire logic        dma_irq_req,                  // dma irq
   input wire logic [15:0] reg_rdata,                    // read data
   input wire logic [7:0]  index,                        // index
   input wire logic        source_a_flag,                // flag A
   input wire logic        source_b_flag,                // flag B
   input wire logic        irq_request                   // irq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence s_access;
      reg_wr && indexed_bank_select && !index_load;
   endsequence
   property p_reset_zero;
      $fell(rst) |-> index == 8'h00 && !source_a_flag && !source_b_flag && !irq_request;
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("outputs not zero after reset");
   property p_load;
      index_load |=> index == $past(index_load_value);
   endproperty
   a_load: assert property (p_load) else $error("index load lost");
   property p_step;
      s_access ##0 !auto_index_increment_disable |=>
         index == $past(index) + ($past(reg_word) ? 8'h02 : 8'h01);
   endproperty
   a_step: assert property (p_step) else $error("index step wrong");
   property p_frozen;
      s_access ##0 auto_index_increment_disable |=> $stable(index);
   endproperty
   a_frozen: assert property (p_frozen) else $error("index moved while frozen");
   property p_bank_low;
      !indexed_bank_select |=> reg_rdata == 16'h0000;
   endproperty
   a_bank_low: assert property (p_bank_low) else $error("read data with bank low");
   property p_a_hold;
      source_a_flag && !status_flag_clear |=> source_a_flag;
   endproperty
   a_a_hold: assert property (p_a_hold) else $error("flag A dropped");
   property p_b_clear;
      $fell(source_b_flag) |-> $past(status_flag_clear);
   endproperty
   a_b_clear: assert property (p_b_clear) else $error("flag B dropped");
   property p_dma_pass;
      dma_irq_req |=> irq_request;
   endproperty
   a_dma_pass: assert property (p_dma_pass) else $error("dma irq suppressed");
endmodule // irq_source_checker
bind irq_source_config irq_source_checker i_chk (.sys_clk(sys_clk), .rst(rst),
   .indexed_bank_select(indexed_bank_select), .index_load(index_load), .reg_wr(reg_wr),
   .auto_index_increment_disable(auto_index_increment_disable), .reg_word(reg_word),
   .index_load_value(index_load_value), .status_flag_clear(status_flag_clear),
   .dma_irq_req(dma_irq_req), .reg_rdata(reg_rdata), .index(index), .irq_request(irq_request),
   .source_a_flag(source_a_flag), .source_b_flag(source_b_flag));
`default_nettype wire

//--- tb/irq_source_config_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin num_errors++; \
   $display("ERROR %s expected %0h seen %0h", n, e, a); end end
module irq_source_config_bench
   import irq_source_pkg::*;
;
   logic        sys_clk = 1'b0, rst = 1'b1, aid = 1'b0, ld = 1'b0, wr = 1'b0, rd = 1'b0;
   logic        wd = 1'b0, clr = 1'b0, cls = 1'b0, dmi = 1'b0, ffi = 1'b0, dme = 1'b0;
   logic        bank = 1'b1;
   index_t      ldv = 8'h00;
   logic [15:0] wdat = 16'h0000;
   logic [3:0]  din = 4'h0, chan = 4'hA, ev = 4'h0;
   logic [15:0] rdata;
   index_t      idx;
   logic [3:0]  nib;
   logic        fa, fb, enh, irq, tp;
   int          num_errors = 0, comparisons = 0, cyc = 0, pulses = 0;
   irq_source_config i_dut (.sys_clk(sys_clk), .rst(rst), .indexed_bank_select(bank),
      .auto_index_increment_disable(aid), .index_load(ld), .index_load_value(ldv),
      .reg_wr(wr), .reg_rd(rd), .reg_word(wd), .reg_wdata(wdat), .digital_input(din),
      .adc_channel(chan), .sample_done(ev[0]), .frame_max(ev[1]), .trig_start(ev[2]),
      .trig_stop(ev[3]), .status_flag_clear(clr), .classic_irq_req(cls), .dma_irq_req(dmi),
      .fifo_irq_req(ffi), .dma_enable(dme), .reg_rdata(rdata), .index(idx),
      .status_low_nibble(nib), .source_a_flag(fa), .source_b_flag(fb),
      .enhanced_selection(enh), .irq_request(irq), .threshold_pulse(tp));
   always #12.5 sys_clk = ~sys_clk;
   // hang guard: the whole run takes about 1250 cycles
   always @(posedge sys_clk)
   begin
      cyc++;
      if (tp === 1'b1) pulses++;
      if (cyc == 5000)
      begin
         num_errors++;
         report_and_stop();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic wr_reg(input index_t a, input logic [15:0] d, input logic w);
      ld = 1'b1;
      ldv = a;
      tick(1);
      {ld, wr, wd, wdat} = {1'b0, 1'b1, w, d};
      tick(1);
      {wr, wd} = 2'b00;
   endtask
   task automatic chk_reg(input index_t a, input logic [15:0] e);
      ld = 1'b1;
      ldv = a;
      tick(1);
      {ld, rd} = 2'b01;
      tick(1);
      rd = 1'b0;
      `CHK("reg_rdata", e, rdata)
   endtask
   task automatic pulse(input logic [3:0] m);
      {ev, clr} = {m, m == 4'h0};
      tick(1);
      {ev, clr} = 5'h00;
      tick(1);
   endtask
   task automatic t_config();
      chk_reg(8'h04, 16'h0000);
      `CHK("index", 8'h05, idx)
      wr_reg(8'h04, 16'hF0A5, 1'b1);
      `CHK("index", 8'h06, idx)
      `CHK("enh", 1'b1, enh)
      chk_reg(8'h04, 16'hF005);
      wr_reg(8'h05, 16'h003C, 1'b0);
      chk_reg(8'h04, 16'h3C05);
      `CHK("enh", 1'b0, enh)
      aid = 1'b1;
      wr_reg(8'h02, 16'h0000, 1'b0);
      `CHK("index", 8'h02, idx)
      {aid, bank} = 2'b00;
      wr_reg(8'h05, 16'h0040, 1'b0);
      bank = 1'b1;
      chk_reg(8'h04, 16'h3C05);
      $display("config done");
   endtask
   task automatic t_flags();
      logic [3:0] none_codes[4] = '{4'h0, 4'h1, 4'h6, 4'h7};
      wr_reg(8'h05, 16'h0040, 1'b0);
      wr_reg(8'h02, 16'h0054, 1'b0);
      pulse(4'b0100);
      `CHK("flags", 2'b01, {fb, fa})
      `CHK("nib", 4'b0001, nib)
      pulse(4'h0);
      pulse(4'b1000);
      `CHK("flags", 2'b10, {fb, fa})
      foreach (none_codes[i])
      begin
         wr_reg(8'h02, {8'h00, none_codes[i], none_codes[i]}, 1'b0);
         chk_reg(8'h02, {8'h00, none_codes[i], none_codes[i]});
         pulse(4'h0);
         pulse(4'hF);
         `CHK("flags", 2'b00, {fb, fa})
      end
      wr_reg(8'h02, 16'h0033, 1'b0);
      wr_reg(8'h05, 16'h0000, 1'b0);
      pulse(4'b0010);
      `CHK("flags", 2'b00, {fb, fa})
      `CHK("nib", chan, nib)
      wr_reg(8'h05, 16'h0040, 1'b0);
      pulse(4'b0010);
      `CHK("flags", 2'b11, {fb, fa})
      for (int i = 0; i < 4; i++)
      begin
         wr_reg(8'h02, {8'h00, 4'(9 + 2 * i), 4'(8 + 2 * i)}, 1'b0);
         pulse(4'h0);
         din[i] = 1'b1;
         tick(8);
         `CHK("din rise", 2'b01, {fb, fa})
         din[i] = 1'b0;
         tick(8);
         `CHK("din fall", 2'b11, {fb, fa})
      end
      $display("flags done");
   endtask
   task automatic t_thresh();
      wr_reg(8'h08, 16'h0003, 1'b1);
      wr_reg(8'h05, 16'h0041, 1'b0);
      wr_reg(8'h02, 16'h0020, 1'b0);
      pulse(4'h0);
      pulses = 0;
      repeat (6) pulse(4'b0001);
      `CHK("pulses", 2, pulses)
      `CHK("flag B", 1'b1, fb)
      wr_reg(8'h05, 16'h0051, 1'b0);
      pulses = 0;
      repeat (2) pulse(4'b0001);
      pulse(4'b0100);
      repeat (2) pulse(4'b0001);
      `CHK("pulses", 0, pulses)
      pulse(4'b0001);
      `CHK("pulses", 1, pulses)
      wr_reg(8'h08, 16'h0001, 1'b1);
      wr_reg(8'h05, 16'h0042, 1'b0);
      pulses = 0;
      repeat (256) pulse(4'b0001);
      `CHK("pulses", 1, pulses)
      repeat (256) pulse(4'b0001);
      `CHK("pulses", 2, pulses)
      wr_reg(8'h05, 16'h004B, 1'b0);
      pulses = 0;
      din[1] = 1'b1;
      tick(8);
      `CHK("pulses", 0, pulses)
      din[1] = 1'b0;
      tick(8);
      `CHK("pulses", 1, pulses)
      $display("threshold done");
   endtask
   task automatic t_irq();
      logic [4:0] steps[5] = '{5'b00010, 5'b10010, 5'b10011, 5'b11000, 5'b10100};
      logic       want[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
      foreach (steps[i])
      begin
         wr_reg(8'h05, {10'h000, steps[i][4], 5'h00}, 1'b0);
         {dmi, ffi, cls, dme} = steps[i][3:0];
         tick(2);
         `CHK("irq", want[i], irq)
      end
      {dmi, ffi, cls, dme} = 4'h0;
      $display("irq done");
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      tick(3);
      rst = 1'b0;
      tick(1);
      t_config();
      t_flags();
      t_thresh();
      t_irq();
      report_and_stop();
   end
endmodule // irq_source_config_bench
`default_nettype wire
